/* host_model.sv */
`timescale 1ns/100ps
module host_model
  import mux_port_pkg::*;
(
  // Clock and configuration
  input wire logic clock,
  input wire port_cfg_t cfg,
  // Host side of the pins and bus
  output ctrl_pins_t pins,
  output logic [15:0] bus_q,
  output logic [15:0] bus_oe,
  input wire logic [15:0] ad_in
);
  initial begin
    pins = 5'h00;
    bus_q = 16'h0000;
    bus_oe = 16'h0000;
  end

  task automatic idle();
    pins = {~cfg.ale_active_high, ~cfg.ale_active_high, ~cfg.cs_active_high,
      ~cfg.rd_dir_active_high, ~cfg.wr_en_active_high};
    bus_oe = 16'h0000;
  endtask

  // The address stays on the bus three cycles past the strobe, since the
  // port sees the pins only through its synchronisers.
  task automatic latch(input logic hi, input logic [15:0] val,
    input logic cs);
    @(negedge clock);
    bus_q = val;
    bus_oe = 16'hffff;
    pins.chip_select = cs ~^ cfg.cs_active_high;
    repeat (3) @(negedge clock);
    pins.addr_latch_high_strobe = hi ~^ cfg.ale_active_high;
    pins.addr_latch_low_strobe = !hi ~^ cfg.ale_active_high;
    repeat (4) @(negedge clock);
    pins.addr_latch_high_strobe = ~cfg.ale_active_high;
    pins.addr_latch_low_strobe = ~cfg.ale_active_high;
    repeat (3) @(negedge clock);
    idle();
  endtask

  // In 8-bit reads the host keeps the upper address on the high lines.
  task automatic access(input logic wr, cs, input logic [15:0] d,
    output logic [15:0] got);
    @(negedge clock);
    bus_q = d;
    bus_oe = wr ? 16'hffff : (cfg.width_8bit ? 16'hff00 : 16'h0000);
    pins.chip_select = cs ~^ cfg.cs_active_high;
    pins.rd_or_dir = (cfg.dir_enable_mode ? wr : !wr) ~^ cfg.rd_dir_active_high;
    @(negedge clock);
    pins.wr_or_transfer_strobe = (cfg.dir_enable_mode | wr)
      ~^ cfg.wr_en_active_high;
    repeat (8) @(negedge clock);
    got = ad_in;
    pins.wr_or_transfer_strobe = ~cfg.wr_en_active_high;
    if (!cfg.dir_enable_mode) pins.rd_or_dir = ~cfg.rd_dir_active_high;
    repeat (3) @(negedge clock);
    idle();
    repeat (3) @(negedge clock);
  endtask
endmodule

/* mux_port_pkg.sv */
package mux_port_pkg;

  // Static configuration of the port, normally held in a mode register.
  typedef struct packed {
    logic dir_enable_mode;
    logic single_phase;
    logic width_8bit;
    logic ale_cs_qualify;
    logic ale_active_high;
    logic cs_active_high;
    logic rd_dir_active_high;
    logic wr_en_active_high;
  } port_cfg_t;

  // Control pins as seen at the package balls.
  typedef struct packed {
    logic addr_latch_low_strobe;
    logic addr_latch_high_strobe;
    logic chip_select;
    logic rd_or_dir;
    logic wr_or_transfer_strobe;
  } ctrl_pins_t;

  typedef enum logic [1:0] {
    cyc_idle,
    cyc_read,
    cyc_write
  } cycle_state_t;

endpackage

/* mux_port_regs.svh */
`ifndef MUX_PORT_REGS_SVH
`define MUX_PORT_REGS_SVH

// ----------------------------------------------------------------------
// Bus widths and field positions
// ----------------------------------------------------------------------
`define AD_WIDTH 16
`define BYTE_LO_MSB 7
`define BYTE_HI_LSB 8
`define BYTE_HI_MSB 15

// ----------------------------------------------------------------------
// Reset values, drive patterns and synchroniser depth
// ----------------------------------------------------------------------
`define ADDR_RESET 16'h0000
`define DATA_RESET 16'h0000
`define OE_NONE 16'h0000
`define OE_LOW_BYTE 16'h00ff
`define OE_FULL_WORD 16'hffff
`define SYNC_STAGES 2

`endif

/* muxed_addr_data_host_port.sv */
`timescale 1ns/100ps
`include "mux_port_regs.svh"
// Function
// - Single-phase latch takes low and high address bytes together.
// - 8-bit data phase never drives or samples the upper bus half.
// - 8-bit mode transfers read and write data on the low lines only.
// - Any mix of reads and writes reuses one latched address.
// - Mode bit picks separate strobes or direction plus enable.
// - Direction plus enable works the same in every addressing variant.
// - Direction and enable polarities are configurable.
// - Select, read and write pins each have their own polarity; both latch pins share one.
// - Optional qualification of latch strobes by chip select.
// - Dual-phase high and low latch cycles accepted in either order.
// - Read, write and address cycles may follow each other freely.
// - Separate strobes start a cycle with select active, end on release.
// - Enable starts a cycle with select, direction chooses read or write.
// - A skipped latch cycle reuses the last latched address.

module muxed_addr_data_host_port
  import mux_port_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Static configuration
  input wire port_cfg_t cfg,
  // Host control pins
  input wire ctrl_pins_t pins,
  // Shared address and data bus
  input wire logic [`AD_WIDTH-1:0] ad_in,
  output logic [`AD_WIDTH-1:0] ad_out,
  output logic [`AD_WIDTH-1:0] ad_oe,
  // Internal access side
  output logic [`AD_WIDTH-1:0] addr_q,
  output logic rd_req_q,
  input wire logic [`AD_WIDTH-1:0] rd_data,
  output logic wr_req_q,
  output logic [`AD_WIDTH-1:0] wr_data_q,
  output logic wide_q
);

  // --------------------------------------------------------------------
  // Synchronisers and polarity
  // --------------------------------------------------------------------
  ctrl_pins_t pins_s;
  logic [`AD_WIDTH-1:0] ad_s;
  logic [`AD_WIDTH-1:0] ad_d1_q;
  logic ale_lo, ale_hi, cs_act, rd_act, wr_act;
  logic ale_lo_q, ale_hi_q, rd_q, wr_q;
  logic lo_hit_q, hi_hit_q;
  cycle_state_t state_q;
  logic [1:0] settle_q;
  logic settled;

  function automatic logic active(input logic level, input logic high);
    active = (level == high);
  endfunction

  pin_sync #(.WIDTH(5)) ctrl_sync (
    .clock(clock),
    .resetn(resetn),
    .async_in(pins),
    .sync_out(pins_s)
  );

  pin_sync #(.WIDTH(`AD_WIDTH)) bus_sync (
    .clock(clock),
    .resetn(resetn),
    .async_in(ad_in),
    .sync_out(ad_s)
  );

  // Strobes are held off until the synchronisers carry real pin levels;
  // their reset value would look active under low-active polarities.
  assign settled = (settle_q == 2'(`SYNC_STAGES));

  // Each pin is normalised with its polarity bit; both latch strobes share cfg.ale_active_high.
  assign ale_lo = settled && active(pins_s.addr_latch_low_strobe,
                         cfg.ale_active_high);
  assign ale_hi = settled && active(pins_s.addr_latch_high_strobe,
                         cfg.ale_active_high);
  assign cs_act = active(pins_s.chip_select, cfg.cs_active_high);
  assign rd_act = settled && active(pins_s.rd_or_dir,
                         cfg.rd_dir_active_high);
  assign wr_act = settled && active(pins_s.wr_or_transfer_strobe,
                         cfg.wr_en_active_high);

  // --------------------------------------------------------------------
  // Edge history
  // --------------------------------------------------------------------
  // The bus is sampled one cycle behind so the address still stands
  // when the strobe release is seen.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ale_lo_q <= 1'b0;
      ale_hi_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      ad_d1_q <= `DATA_RESET;
      settle_q <= 2'h0;
    end else begin
      if (!settled) begin
        settle_q <= settle_q + 2'h1;
      end
      ale_lo_q <= ale_lo;
      ale_hi_q <= ale_hi;
      rd_q <= rd_act;
      wr_q <= wr_act;
      ad_d1_q <= ad_s;
    end
  end

  // --------------------------------------------------------------------
  // Address latching
  // --------------------------------------------------------------------
  // A latch strobe counts if chip select was seen at any point of it.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      lo_hit_q <= 1'b0;
      hi_hit_q <= 1'b0;
    end else begin
      if (!ale_lo) begin
        lo_hit_q <= 1'b0;
      end else if (!cfg.ale_cs_qualify || cs_act) begin
        lo_hit_q <= 1'b1;
      end
      if (!ale_hi) begin
        hi_hit_q <= 1'b0;
      end else if (!cfg.ale_cs_qualify || cs_act) begin
        hi_hit_q <= 1'b1;
      end
    end
  end

  logic lo_fall, hi_fall;
  assign lo_fall = ale_lo_q && !ale_lo && lo_hit_q;
  assign hi_fall = ale_hi_q && !ale_hi && hi_hit_q;

  // Without a new strobe the address simply holds, which also serves
  // repeated accesses to one location.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      addr_q <= `ADDR_RESET;
    end else if (cfg.single_phase) begin
      if (lo_fall) begin
        addr_q <= ad_d1_q;
      end
    end else begin
      if (lo_fall) begin
        addr_q[`BYTE_LO_MSB:0] <= ad_d1_q[`BYTE_LO_MSB:0];
      end
      if (hi_fall) begin
        addr_q[`BYTE_HI_MSB:`BYTE_HI_LSB] <=
          ad_d1_q[`BYTE_LO_MSB:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Cycle control
  // --------------------------------------------------------------------
  logic start_rd, start_wr, cyc_end;

  // Enable is the write pin in direction mode; direction is the read pin.
  always_comb begin
    if (cfg.dir_enable_mode) begin
      start_rd = wr_act && !wr_q && cs_act && !rd_act;
      start_wr = wr_act && !wr_q && cs_act && rd_act;
    end else begin
      start_rd = rd_act && !rd_q && cs_act;
      start_wr = wr_act && !wr_q && cs_act;
    end
  end

  always_comb begin
    if (cfg.dir_enable_mode || state_q == cyc_write) begin
      cyc_end = !wr_act;
    end else begin
      cyc_end = !rd_act;
    end
  end

  // Any cycle may follow any other once the previous one has ended.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= cyc_idle;
    end else begin
      case (state_q)
        cyc_idle: begin
          if (start_rd) begin
            state_q <= cyc_read;
          end else if (start_wr) begin
            state_q <= cyc_write;
          end
        end
        cyc_read, cyc_write: begin
          if (cyc_end) begin
            state_q <= cyc_idle;
          end
        end
        default: begin
          state_q <= cyc_idle;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Internal access side
  // --------------------------------------------------------------------
  // Writes commit at strobe release, where the host data is settled.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rd_req_q <= 1'b0;
      wr_req_q <= 1'b0;
      wr_data_q <= `DATA_RESET;
      wide_q <= 1'b0;
    end else begin
      rd_req_q <= (state_q == cyc_idle) && start_rd;
      wr_req_q <= (state_q == cyc_write) && cyc_end;
      wide_q <= !cfg.width_8bit;
      if (state_q == cyc_write && cyc_end) begin
        if (cfg.width_8bit) begin
          wr_data_q <= {8'h00, ad_d1_q[`BYTE_LO_MSB:0]};
        end else begin
          wr_data_q <= ad_d1_q;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Bus drive
  // --------------------------------------------------------------------
  // The bus is released as soon as the read ends; a few cycles of
  // synchroniser lag is the price of sampling asynchronous strobes.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ad_oe <= `OE_NONE;
      ad_out <= `DATA_RESET;
    end else if (state_q == cyc_read && !cyc_end) begin
      if (cfg.width_8bit) begin
        ad_oe <= `OE_LOW_BYTE;
        ad_out <= {8'h00, rd_data[`BYTE_LO_MSB:0]};
      end else begin
        ad_oe <= `OE_FULL_WORD;
        ad_out <= rd_data;
      end
    end else begin
      ad_oe <= `OE_NONE;
      ad_out <= `DATA_RESET;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence read_begins;
    state_q == cyc_idle && start_rd;
  endsequence

  sequence read_held;
    state_q == cyc_read && !cyc_end;
  endsequence

  drive_only_read_a: assert property (
    ad_oe != `OE_NONE |-> $past(state_q == cyc_read && !cyc_end))
    else $error("bus driven outside a read cycle");

  upper_half_quiet_a: assert property (
    cfg.width_8bit && $past(cfg.width_8bit) |->
      ad_oe[`BYTE_HI_MSB:`BYTE_HI_LSB] == 8'h00)
    else $error("upper bus half driven in 8-bit mode");

  read_drives_bus_a: assert property (
    read_begins ##1 read_held |=> ad_oe != `OE_NONE)
    else $error("read cycle did not drive the bus");

  read_request_once_a: assert property (
    read_begins |=> rd_req_q ##1 !rd_req_q)
    else $error("read request not a single pulse");

  write_commit_a: assert property (
    state_q == cyc_write && cyc_end |=> wr_req_q && state_q == cyc_idle)
    else $error("write did not commit at strobe release");

  byte_write_low_a: assert property (
    wr_req_q && cfg.width_8bit && $past(cfg.width_8bit, 2) |->
      wr_data_q[`BYTE_HI_MSB:`BYTE_HI_LSB] == 8'h00)
    else $error("upper byte written in 8-bit mode");

  addr_holds_a: assert property (
    !lo_fall && !hi_fall |=> $stable(addr_q))
    else $error("address changed without a latch strobe");

  single_latch_a: assert property (
    cfg.single_phase && lo_fall |=> addr_q == $past(ad_d1_q))
    else $error("single-phase latch lost an address byte");

  high_latch_a: assert property (
    !cfg.single_phase && hi_fall |=>
      addr_q[`BYTE_HI_MSB:`BYTE_HI_LSB] == $past(ad_d1_q[`BYTE_LO_MSB:0]))
    else $error("dual-phase high address not latched");

  qualify_gate_a: assert property (
    cfg.ale_cs_qualify && ale_lo && !cs_act && !lo_hit_q |=> !lo_hit_q)
    else $error("latch strobe accepted without chip select");

endmodule

/* muxed_addr_data_host_port_tb.sv */
`timescale 1ns/100ps
module muxed_addr_data_host_port_tb
  import mux_port_pkg::*;
;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  port_cfg_t cfg = 8'h00;
  ctrl_pins_t pins;
  logic [15:0] bus_q, bus_oe, ad_in, ad_out, ad_oe, addr_q, wr_data_q;
  logic [15:0] rd_data = 16'hc3a5;
  logic [15:0] flt = 16'h5555;
  logic [15:0] m, oe_or, rd_a, wr_a, wr_d;
  logic rd_req_q, wr_req_q;
  logic wide_q;
  int err_count = 0;
  int total_checks = 0;
  int rd_n = 0;
  int wr_n = 0;
  port_cfg_t cfgs [6] = '{8'h4f, 8'h70, 8'h9b, 8'ha4, 8'h2a, 8'hc5};

  always #5 clock = ~clock;
  always @(posedge clock) flt <= ~flt;
  // Undriven bits toggle, so a stale bus value never passes for data.
  assign ad_in = (ad_oe & ad_out) | (~ad_oe & bus_oe & bus_q)
    | (~ad_oe & ~bus_oe & flt);

  muxed_addr_data_host_port uut (
    .clock(clock), .resetn(resetn), .cfg(cfg), .pins(pins),
    .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .addr_q(addr_q),
    .rd_req_q(rd_req_q), .rd_data(rd_data), .wr_req_q(wr_req_q),
    .wr_data_q(wr_data_q), .wide_q(wide_q));

  host_model host (
    .clock(clock), .cfg(cfg), .pins(pins), .bus_q(bus_q),
    .bus_oe(bus_oe), .ad_in(ad_in));

  always @(posedge clock) begin
    oe_or <= oe_or | ad_oe;
    if (rd_req_q === 1'b1) begin
      rd_n <= rd_n + 1;
      rd_a <= addr_q;
    end
    if (wr_req_q === 1'b1) begin
      wr_n <= wr_n + 1;
      wr_a <= addr_q;
      wr_d <= wr_data_q;
    end
  end

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic op(input logic wr, cs, input logic [15:0] d, x);
    int r0;
    int w0;
    logic [15:0] got;
    r0 = rd_n;
    w0 = wr_n;
    oe_or = 16'h0000;
    host.access(wr, cs, d, got);
    chk(16'(rd_n - r0), {15'h0000, cs & !wr});
    chk(16'(wr_n - w0), {15'h0000, cs & wr});
    chk(ad_oe, 16'h0000);
    chk(oe_or, (cs & !wr) ? m : 16'h0000);
    if (cs & wr) chk(wr_d, d & m);
    if (cs & wr) chk(wr_a, x);
    if (cs & !wr) chk(rd_a, x);
    if (cs & !wr) chk(got, rd_data & m | d & ~m);
  endtask

  task automatic run(input port_cfg_t c, input logic [15:0] a);
    logic [15:0] x;
    logic [15:0] d;
    logic h;
    int r0;
    @(negedge clock);
    resetn = 1'b0;
    cfg = c;
    m = c.width_8bit ? 16'h00ff : 16'hffff;
    @(negedge clock);
    host.idle();
    repeat (5) @(negedge clock);
    resetn = 1'b1;
    oe_or = 16'h0000;
    r0 = rd_n;
    repeat (4) @(negedge clock);
    chk(oe_or, 16'h0000);
    chk(16'(rd_n - r0), 16'h0000);
    chk({15'h0000, wide_q}, {15'h0000, !c.width_8bit});
    for (int k = 0; k < (c.width_8bit ? 4 : 2); k++) begin
      x = a + 16'(k * (c.width_8bit ? 1 : 2));
      for (int j = 0; j < 2 - c.single_phase; j++) begin
        h = (j[0] ^ k[0]) & !c.single_phase;
        host.latch(h, h ? {x[7:0], x[15:8]}
          : (c.single_phase ? x : {~x[15:8], x[7:0]}), 1'b1);
      end
      d = x ^ (c.width_8bit ? 16'h0096 : 16'h96c3);
      op(1'b1, 1'b1, d, x);
      op(1'b0, 1'b1, d, x);
    end
    host.latch(1'b0, ~x, 1'b0);
    if (!c.ale_cs_qualify) x = c.single_phase ? ~x : {x[15:8], ~x[7:0]};
    d = {x[15:8], ~x[7:0]};
    for (int q = 0; q < 7; q++) begin
      op(1'(7'b0110010 >> q), q > 1, d, x);
    end
  endtask

  initial begin
    for (int i = 0; i < 6; i++) begin
      run(cfgs[i], 16'h2460 + 16'(i) * 16'h1104);
      $display("test %0d done", i);
    end
    summarize();
  end

  // A hung handshake ends the run here as a mismatch.
  initial begin
    #500000;
    err_count++;
    summarize();
  end
endmodule

/* pin_sync.sv */
`timescale 1ns/100ps
`include "mux_port_regs.svh"

module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Asynchronous input and its synchronised copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : width_check
    $error("pin_sync needs a width of at least one");
  end

  // The first stage feeds only the second one.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
